// ---- adc_serial_pkg.sv ----
// constants and types for the converter's serial configuration/readout port
// assumes a single 10 MHz system clock; all link pins are asynchronous
// Functional notes
// [R1] A rising convert strobe starts a conversion regardless of readout timing.
// [R2] The first 14 shift clock rising edges of an access latch the config word.
// [R3] The result leaves on the first 15 falling edges, or 16 in busy mode.
// [R4] With readback on, 14 more falling edges return the config word MSB first.
// [R5] The host accesses the port only while the convert strobe is low.
// [R6] An access in conversion n returns result n-1 and configures n+1.
// [R7] The host lowers the strobe after starting a conversion before accessing.
// [R8] The host finishes all shift edges inside the safe access window.
// [R9] Late digital activity is corrected only before the safe window ends.
// [R10] The host keeps pins quiet around the strobe rising edge if it can.
// [R11] An access in acquisition n returns n-1 and its write applies to n+1.
// [R12] A spanning access is split into two bursts around the strobe pulse.
// [R13] The converter powers down at the end of every conversion phase.
// [R14] The host writes config and starts busy indication before the window ends.
// [R15] The host should gate the shift clock to access bursts only.
// [R16] The config word enters MSB first and takes effect at conversion end.
// [R17] Two conversions with the config input held high load 0x3FFF.
package adc_serial_pkg;
	localparam int          CFG_W         = 14;
	localparam int          RES_W         = 16;
	localparam int          RES_BITS      = 15;
	localparam int          RES_BITS_BUSY = 16;
	localparam int          CFG_RB_BIT    = 0;
	localparam logic [13:0] CFG_DEFAULT   = 14'h3FFF;
	localparam int          CONV_TIME_NS  = 2200;
	localparam int          DATA_TIME_NS  = 1200;
	localparam int          CLK_PERIOD_NS = 100;
	// longest times round down, never below one cycle
	localparam int CONV_CYC = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(CONV_TIME_NS / CLK_PERIOD_NS);
	localparam int DATA_CYC = (DATA_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(DATA_TIME_NS / CLK_PERIOD_NS);
	typedef enum logic [1:0] {ST_ACQ, ST_CONV} conv_state_t;
endpackage

// ---- adc_serial_port.sv ----
// serial port of a multichannel converter: strobe, shift clock, config in,
// result out. pins are asynchronous to sys_clk and are sampled by 3 flops;
// the shift clock must stay well below sys_clk/4 for edges to be seen.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_port
	import adc_serial_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYC,
	parameter int DATA_CYCLES = DATA_CYC
)(
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	input  wire logic                     convert_strobe,
	input  wire logic                     shift_clk,
	input  wire logic                     config_in,
	input  wire logic [adc_serial_pkg::RES_W-1:0] sample_data,
	input  wire logic                     busy_mode,
	output logic                          serial_result_out,
	output logic                          converting,
	output logic                          powered_down,
	output logic                          safe_window,
	output logic [adc_serial_pkg::CFG_W-1:0] active_config
);
	import adc_serial_pkg::*;

	logic [2:0]          cnv_sy_ff, sck_sy_ff, din_sy_ff;
	logic                cnv_ff, sck_ff, din_ff;
	conv_state_t         state_ff;
	logic [15:0]         cyc_ff;
	logic [CFG_W-1:0]    shift_cfg_ff, pend_cfg_ff, act_cfg_ff, rb_cfg_ff;
	logic                pend_vld_ff;
	logic [4:0]          in_cnt_ff;
	logic [5:0]          out_cnt_ff;
	logic [RES_W-1:0]    result_ff;
	logic [RES_W+CFG_W-1:0] out_sh_ff;
	logic                sdo_ff;
	logic [1:0]          dummy_ff;

	// strobe and shift clock changes accepted once stages 2 and 3 agree; config in takes stage 3 as is; stage 1 feeds stage 2 only
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			cnv_sy_ff <= 3'h0;
			sck_sy_ff <= 3'h0;
			din_sy_ff <= 3'h0;
			cnv_ff    <= 1'b0;
			sck_ff    <= 1'b0;
			din_ff    <= 1'b0;
		end
		else
		begin
			cnv_sy_ff <= {cnv_sy_ff[1:0], convert_strobe};
			sck_sy_ff <= {sck_sy_ff[1:0], shift_clk};
			din_sy_ff <= {din_sy_ff[1:0], config_in};
			if (cnv_sy_ff[1] == cnv_sy_ff[2])
				cnv_ff <= cnv_sy_ff[2];
			if (sck_sy_ff[1] == sck_sy_ff[2])
				sck_ff <= sck_sy_ff[2];
			din_ff <= din_sy_ff[2];
		end
	end

	logic cnv_rise, sck_rise, sck_fall, conv_end;
	assign cnv_rise = !cnv_ff && (cnv_sy_ff[1] == cnv_sy_ff[2]) && cnv_sy_ff[2];
	assign sck_rise = !sck_ff && (sck_sy_ff[1] == sck_sy_ff[2]) && sck_sy_ff[2];
	assign sck_fall = sck_ff && (sck_sy_ff[1] == sck_sy_ff[2]) && !sck_sy_ff[2];
	assign conv_end = (state_ff == ST_CONV) &&
		(cyc_ff == 16'(CONV_CYCLES - 1));

	// conversion timing; strobe edges during conversion are ignored
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			state_ff <= ST_ACQ;
			cyc_ff   <= 16'h0000;
		end
		else
		begin
			case (state_ff)
				ST_ACQ:
					if (cnv_rise) // R1
					begin
						state_ff <= ST_CONV;
						cyc_ff   <= 16'h0000;
					end
				ST_CONV:
					if (conv_end)
						state_ff <= ST_ACQ; // R13
					else
						cyc_ff <= cyc_ff + 16'h0001;
				default:
					state_ff <= ST_ACQ;
			endcase
		end
	end

	// an access is bounded by the strobe: high resets the bit counters
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			in_cnt_ff    <= 5'h00;
			shift_cfg_ff <= 14'h0000;
			pend_cfg_ff  <= CFG_DEFAULT;
			pend_vld_ff  <= 1'b0;
		end
		else
		begin
			// clear first so a word completed in the same cycle stays pending
			if (conv_end)
				pend_vld_ff <= 1'b0;
			if (cnv_ff)
				in_cnt_ff <= 5'h00; // R5
			else if (sck_rise && in_cnt_ff < 5'(CFG_W)) // R2
			begin
				shift_cfg_ff <= {shift_cfg_ff[CFG_W-2:0], din_ff}; // R16
				in_cnt_ff    <= in_cnt_ff + 5'h01;
				if (in_cnt_ff == 5'(CFG_W - 1))
				begin
					pend_cfg_ff <= {shift_cfg_ff[CFG_W-2:0], din_ff};
					pend_vld_ff <= 1'b1;
				end
			end
		end
	end

	// config and result advance only at conversion end, one access deep
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			act_cfg_ff <= CFG_DEFAULT;
			rb_cfg_ff  <= CFG_DEFAULT;
			result_ff  <= 16'h0000;
			dummy_ff   <= 2'h0;
		end
		else if (conv_end)
		begin
			result_ff <= sample_data; // R6
			rb_cfg_ff <= act_cfg_ff; // R4
			if (pend_vld_ff)
				act_cfg_ff <= pend_cfg_ff; // R16
			else if (dummy_ff != 2'h2 && din_ff)
				act_cfg_ff <= CFG_DEFAULT; // R17
			if (dummy_ff != 2'h2)
				dummy_ff <= dummy_ff + 2'h1;
		end
	end

	logic       rb_on;
	logic [5:0] out_len;
	assign rb_on   = act_cfg_ff[CFG_RB_BIT] == 1'b0;
	assign out_len = 6'(busy_mode ? RES_BITS_BUSY : RES_BITS) +
		(rb_on ? 6'(CFG_W) : 6'h00);

	// result shifts out on falling edges; first bit shown while strobe is high
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			out_cnt_ff <= 6'h00;
			out_sh_ff  <= '0;
			sdo_ff     <= 1'b0;
		end
		else if (cnv_ff)
		begin
			out_cnt_ff <= 6'h00;
			out_sh_ff  <= {result_ff, rb_cfg_ff}; // R4
			sdo_ff     <= result_ff[RES_W-1];
		end
		// a read not yet begun at conversion end offers the fresh result
		else if (conv_end && in_cnt_ff == 5'h00 && out_cnt_ff == 6'h00)
		begin
			out_sh_ff <= {sample_data, act_cfg_ff}; // R6
			sdo_ff    <= sample_data[RES_W-1];
		end
		else if (sck_fall && out_cnt_ff < out_len) // R3
		begin
			out_sh_ff  <= {out_sh_ff[RES_W+CFG_W-2:0], 1'b0};
			sdo_ff     <= out_sh_ff[RES_W+CFG_W-2];
			out_cnt_ff <= out_cnt_ff + 6'h01;
		end
	end

	assign serial_result_out = sdo_ff;
	assign converting        = state_ff == ST_CONV;
	assign powered_down      = state_ff == ST_ACQ; // R13
	assign safe_window       = (state_ff == ST_CONV) &&
		(cyc_ff < 16'(DATA_CYCLES)); // R9
	assign active_config     = act_cfg_ff;

	property p_conv_start; // R1
		@(posedge sys_clk) disable iff (!reset_n)
		(state_ff == ST_ACQ && cnv_rise) |=> converting;
	endproperty
	a_conv_start: assert property (p_conv_start) // R1
		else $error("conversion did not start on strobe rise");

	property p_conv_len; // R13
		@(posedge sys_clk) disable iff (!reset_n)
		$rose(converting) |-> converting [*8];
	endproperty
	a_conv_len: assert property (p_conv_len) // R13
		else $error("conversion ended too early");

	property p_cfg_count; // R2
		@(posedge sys_clk) disable iff (!reset_n)
		in_cnt_ff <= 5'(CFG_W);
	endproperty
	a_cfg_count: assert property (p_cfg_count) // R2
		else $error("more than 14 config bits taken");

	property p_cfg_latch; // R16
		@(posedge sys_clk) disable iff (!reset_n)
		(conv_end && pend_vld_ff) |=> (act_cfg_ff == $past(pend_cfg_ff));
	endproperty
	a_cfg_latch: assert property (p_cfg_latch) // R16
		else $error("pending config not applied at conversion end");

	property p_cfg_hold; // R6
		@(posedge sys_clk) disable iff (!reset_n)
		!conv_end |=> $stable(act_cfg_ff);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) // R6
		else $error("config changed outside conversion end");

	property p_res_load; // R6
		@(posedge sys_clk) disable iff (!reset_n)
		conv_end |=> (result_ff == $past(sample_data));
	endproperty
	a_res_load: assert property (p_res_load) // R6
		else $error("result not captured at conversion end");

	property p_res_show; // R6
		@(posedge sys_clk) disable iff (!reset_n)
		(conv_end && !cnv_ff && in_cnt_ff == 5'h00 && out_cnt_ff == 6'h00)
			|=> (out_sh_ff[RES_W+CFG_W-1:CFG_W] == $past(sample_data));
	endproperty
	a_res_show: assert property (p_res_show) // R6
		else $error("fresh result not offered after conversion end");

	property p_out_bound; // R3
		@(posedge sys_clk) disable iff (!reset_n)
		out_cnt_ff <= 6'(RES_BITS_BUSY + CFG_W);
	endproperty
	a_out_bound: assert property (p_out_bound) // R3
		else $error("too many output bits");

	sequence s_strobe_high;
		cnv_ff [*2];
	endsequence
	property p_out_reset; // R5
		@(posedge sys_clk) disable iff (!reset_n)
		s_strobe_high |-> (out_cnt_ff == 6'h00 && in_cnt_ff == 5'h00);
	endproperty
	a_out_reset: assert property (p_out_reset) // R5
		else $error("access counters not cleared while strobe high");

	property p_default; // R17
		@(posedge sys_clk) disable iff (!reset_n)
		(conv_end && !pend_vld_ff && dummy_ff != 2'h2 && din_ff)
			|=> (act_cfg_ff == CFG_DEFAULT);
	endproperty
	a_default: assert property (p_default) // R17
		else $error("default config not loaded");
endmodule
`default_nettype wire

// ---- adc_host_model.sv ----
// host side of the converter's serial port: strobe, shift clock, config line
// assumes the port's 10 MHz sys_clk; shift clock period is 8 sys_clk (800 ns)
`timescale 1ns/1ns
`default_nettype none
module adc_host_model (
	input  wire logic sys_clk,
	input  wire logic serial_result_out,
	output logic      convert_strobe,
	output logic      shift_clk,
	output logic      config_in
);
	// config line starts high so dummy conversions load the default word
	initial
	begin
		convert_strobe = 1'b0;
		shift_clk = 1'b0;
		config_in = 1'b1;
	end

	// short strobe pulse, then low again before any access
	task automatic convert();
		repeat (8) @(negedge sys_clk);
		convert_strobe = 1'b1;
		repeat (2) @(negedge sys_clk);
		convert_strobe = 1'b0;
	endtask

	// gated shift clock, only while the strobe is low; 30 pulses per burst
	task automatic access(input logic [13:0] cfg, output logic [29:0] got);
		for (int i = 0; i < 30; i++)
		begin
			// past the word the line toggles so stale bits would show
			config_in = (i < 14) ? cfg[13 - i] : ~config_in;
			repeat (4) @(negedge sys_clk);
			shift_clk = 1'b1;
			repeat (4) @(negedge sys_clk);
			got[29 - i] = serial_result_out;
			shift_clk = 1'b0;
		end
		repeat (8) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ---- adc_serial_port_tb.sv ----
// self-checking bench for the converter's serial port
// assumes adc_serial_pkg and the host model are compiled first
`timescale 1ns/1ns
`default_nettype none
module adc_serial_port_tb;
	import adc_serial_pkg::*;
	logic             sys_clk, reset_n, busy_mode;
	logic             convert_strobe, shift_clk, config_in;
	logic             serial_result_out, converting, powered_down, safe_window;
	logic [RES_W-1:0] sample_data;
	logic [CFG_W-1:0] active_config;
	logic [29:0]      got;
	int               mismatches, comparisons;

	adc_serial_port #(.CONV_CYCLES(8), .DATA_CYCLES(4)) adc_serial_port_i (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.convert_strobe(convert_strobe), .shift_clk(shift_clk),
		.config_in(config_in), .sample_data(sample_data),
		.busy_mode(busy_mode), .serial_result_out(serial_result_out),
		.converting(converting), .powered_down(powered_down),
		.safe_window(safe_window), .active_config(active_config));
	adc_host_model adc_host_model_i (
		.sys_clk(sys_clk), .serial_result_out(serial_result_out),
		.convert_strobe(convert_strobe), .shift_clk(shift_clk),
		.config_in(config_in));

	initial sys_clk = 1'b0;
	always #50 sys_clk = ~sys_clk;

	task automatic check_bit(input logic act, input logic exp);
		comparisons++;
		if (act !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t flag %b expected %b", $time, act, exp);
		end
	endtask

	task automatic check_word(input logic [29:0] act, input logic [29:0] exp);
		comparisons++;
		if (act !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t word %h expected %h", $time, act, exp);
		end
	endtask

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one conversion; bounded waits on the busy level
	task automatic run_conv(input logic [15:0] smp);
		int n;
		n = 0;
		sample_data = smp;
		adc_host_model_i.convert();
		while (converting !== 1'b1 && n < 20)
		begin
			@(negedge sys_clk);
			n++;
		end
		check_bit(powered_down, 1'b0);
		check_bit(safe_window, 1'b1);
		while (converting !== 1'b0 && n < 60)
		begin
			@(negedge sys_clk);
			n++;
		end
		check_bit(converting, 1'b0);
		check_bit(powered_down, 1'b1);
		repeat (4) @(negedge sys_clk);
	endtask

	// default word has readback off: 16 result bits, then the LSB is held
	task automatic t_first_read();
		run_conv(16'hA5C2);
		adc_host_model_i.access(14'h1A5A, got);
		check_word(got, {16'hA5C2, 14'h0000});
		check_word(active_config, 14'h3FFF);
	endtask

	// written word lands at the next conversion end; readback word is one behind
	task automatic t_pipeline();
		run_conv(16'h3C96);
		check_word(active_config, 14'h1A5A);
		adc_host_model_i.access(14'h1A5A, got);
		check_word(got, {16'h3C96, 14'h3FFF});
	endtask

	// busy mode: 16 result bits, then the config word that was active
	task automatic t_readback_busy();
		busy_mode = 1'b1;
		run_conv(16'hF00D);
		adc_host_model_i.access(14'h0C36, got);
		check_word(got, {16'hF00D, 14'h1A5A});
		busy_mode = 1'b0;
		run_conv(16'h0001);
		check_word(active_config, 14'h0C36);
	endtask

	initial
	begin
		#1000000;
		mismatches++;
		test_done();
	end

	initial
	begin
		mismatches = 0;
		comparisons = 0;
		reset_n = 1'b0;
		busy_mode = 1'b0;
		sample_data = 16'h0000;
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		@(negedge sys_clk);
		check_word(active_config, 14'h3FFF);
		check_bit(powered_down, 1'b1);
		t_first_read();
		t_pipeline();
		t_readback_busy();
		test_done();
	end
endmodule
`default_nettype wire
